/* File: dv/dpa_front_monitor.sv */
// checker for the debug port front end: resource handshake, flags and pin enable
// assumes binding to dpa_front, one mclk domain
`timescale 1ns/10ps
module dpa_front_monitor (
    input wire mclk,
    input wire rst,
    input wire swdio_oe,
    input wire res_req_r,
    input wire [63:0] res_addr_r,
    input wire [31:0] res_wdata_r,
    input wire res_done,
    input wire res_err,
    input wire res_abort_r,
    input wire [3:0] port_class_r,
    input wire [31:0] sticky_r,
    input wire link_busy_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_class_nine: assert property (1 |=> port_class_r == 4'h9)
        else $error("class code wrong");
    a_req_pulse: assert property (res_req_r |=> !res_req_r)
        else $error("request longer than one cycle");
    a_req_busy: assert property (res_req_r |-> link_busy_r)
        else $error("request while idle");
    a_addr_low: assert property (res_req_r |-> res_addr_r[1:0] == 2'h0)
        else $error("address low bits set");
    a_addr_hold: assert property (!res_req_r |-> $stable(res_addr_r) && $stable(res_wdata_r))
        else $error("address moved without request");
    a_req_answer: assert property (res_req_r |-> ##[1:140] (res_done || res_abort_r))
        else $error("access neither done nor aborted");
    a_err_sticky: assert property (res_done && res_err |=> sticky_r[5])
        else $error("error flag not set");
    a_flag_rsvd: assert property ((sticky_r & 32'hFFFF_FF5D) == 32'h0)
        else $error("unknown flag set");
    a_oe_busy: assert property (swdio_oe |-> link_busy_r)
        else $error("pin driven outside a packet");
endmodule

bind dpa_front dpa_front_monitor i_dpa_front_monitor (.mclk(mclk), .rst(rst), .swdio_oe(swdio_oe),
    .res_req_r(res_req_r), .res_addr_r(res_addr_r), .res_wdata_r(res_wdata_r), .res_done(res_done),
    .res_err(res_err), .res_abort_r(res_abort_r), .port_class_r(port_class_r), .sticky_r(sticky_r),
    .link_busy_r(link_busy_r));

/* File: dv/dpa_front_tb_top.sv */
// top of the bench: clock, reset, resource responder and the scenarios
// assumes dpa_front with the host model on its link pins
`timescale 1ns/10ps
module dpa_front_tb_top;
    logic mclk, rst, res_done, res_err, err_mode, last_wr;
    logic [31:0] res_rdata, rd;
    logic [2:0] ack;
    wire swclk, swdio_in, swdio_out, swdio_oe, res_req_r, res_wr_r, res_abort_r, link_busy_r;
    wire [63:0] res_addr_r;
    wire [31:0] res_wdata_r, sticky_r;
    wire [3:0] port_class_r;
    integer n_fail = 0, num_checks = 0, lat = 2, k, j;
    logic [31:0] bank_exp [1:3] = '{32'h40, 32'h3, 32'h0};

    dpa_front i_dpa_front (.mclk(mclk), .rst(rst), .swclk(swclk), .swdio_in(swdio_in), .swdio_out(swdio_out),
        .swdio_oe(swdio_oe), .res_req_r(res_req_r), .res_wr_r(res_wr_r), .res_addr_r(res_addr_r),
        .res_wdata_r(res_wdata_r), .res_rdata(res_rdata), .res_done(res_done), .res_err(res_err),
        .res_abort_r(res_abort_r), .port_class_r(port_class_r), .sticky_r(sticky_r), .link_busy_r(link_busy_r));
    dpa_host i_dpa_host (.mclk(mclk), .swdio_out(swdio_out), .swdio_oe(swdio_oe), .swclk(swclk),
        .swdio_in(swdio_in));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // resource side: answers after lat cycles unless the access is aborted
    always @(posedge mclk) begin
        if (res_req_r === 1'b1) begin
            last_wr = res_wr_r;
            for (k = 0; k < lat && res_abort_r !== 1'b1; k++)
                @(posedge mclk);
            if (res_abort_r !== 1'b1) begin
                #1 res_done = 1'b1;
                res_err = err_mode;
                res_rdata = res_addr_r[31:0] ^ 32'hA5A5_0000;
                @(posedge mclk);
                #1 res_done = 1'b0;
                res_err = 1'b0;
                res_rdata = ~res_rdata;
            end
        end
    end

    task chk(input logic [63:0] got, input logic [63:0] exp);
        begin
            num_checks++;
            if (got !== exp) begin
                n_fail++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task lk(input logic ap, input logic rdn, input logic [1:0] a, input logic bad, input logic [31:0] wd,
            input logic [2:0] ea);
        begin
            i_dpa_host.xfer(ap, rdn, a, bad, wd, ack, rd);
            chk(ack, ea);
            repeat (4) @(posedge mclk);
            for (j = 0; j < 400 && link_busy_r !== 1'b0; j++)
                @(posedge mclk);
            chk(link_busy_r, 1'b0);
        end
    endtask
    task t_ident;
        begin
            chk(port_class_r, 4'h9);
            lk(0, 1, 2'h0, 0, 0, 3'h1);
            chk(rd, 32'h1000_0001);
            for (int b = 1; b < 4; b++) begin
                lk(0, 0, 2'h2, 0, b, 3'h1);
                lk(0, 1, 2'h1, 0, 0, 3'h1);
                chk(rd, bank_exp[b]);
            end
        end
    endtask
    task t_route;
        begin
            lk(0, 0, 2'h2, 0, 32'h5, 3'h1);
            lk(0, 0, 2'h1, 0, 32'hAB, 3'h1);
            lk(0, 0, 2'h2, 0, 32'h1234_5670, 3'h1);
            lk(1, 0, 2'h2, 0, 32'hCAFE_F00D, 3'h1);
            chk(last_wr, 1'b1);
            chk(res_addr_r, 64'hAB_1234_5678);
            chk(res_wdata_r, 32'hCAFE_F00D);
            lk(1, 1, 2'h3, 0, 0, 3'h1);
            chk(last_wr, 1'b0);
            chk(res_addr_r, 64'hAB_1234_567C);
            lk(0, 1, 2'h3, 0, 0, 3'h1);
            chk(rd, 32'hB791_567C);
            lk(1, 1, 2'h0, 0, 0, 3'h1);
            chk(res_addr_r, 64'hAB_1234_5670);
        end
    endtask
    task t_fault;
        begin
            err_mode = 1'b1;
            lk(1, 0, 2'h1, 0, 32'h1, 3'h1);
            err_mode = 1'b0;
            lk(0, 1, 2'h1, 0, 0, 3'h1);
            chk(rd & 32'hA2, 32'h20);
            lk(1, 0, 2'h1, 0, 32'h2, 3'h4);
            lk(0, 0, 2'h0, 0, 32'h4, 3'h1);
            chk(sticky_r[5], 1'b0);
        end
    endtask
    task t_tmo;
        begin
            lat = 300;
            lk(1, 0, 2'h0, 0, 32'h3, 3'h1);
            chk(sticky_r[5], 1'b1);
            lat = 2;
            lk(0, 0, 2'h0, 0, 32'h4, 3'h1);
            chk(sticky_r[5], 1'b0);
        end
    endtask
    task t_reset;
        begin
            err_mode = 1'b1;
            lk(1, 0, 2'h1, 0, 32'h9, 3'h1);
            err_mode = 1'b0;
            chk(sticky_r[5], 1'b1);
            @(posedge mclk);
            #1 rst = 1'b1;
            repeat (2) @(posedge mclk);
            chk(sticky_r, 32'h0);
            chk(res_addr_r, 64'h0);
            chk(port_class_r, 4'h0);
            #1 rst = 1'b0;
            repeat (4) @(posedge mclk);
            chk(port_class_r, 4'h9);
            lk(0, 1, 2'h1, 0, 0, 3'h1);
            chk(rd, 32'h0);
        end
    endtask
    task t_badpar;
        begin
            lk(0, 1, 2'h0, 1, 0, 3'h7);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d failures %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    initial begin
        #400_000;
        n_fail++;
        tally_and_finish;
    end
    initial begin
        rst = 1'b1;
        res_done = 1'b0;
        res_err = 1'b0;
        err_mode = 1'b0;
        res_rdata = 32'h0;
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (4) @(posedge mclk);
        t_ident;
        t_route;
        t_fault;
        t_tmo;
        t_reset;
        t_badpar;
        tally_and_finish;
    end
endmodule

/* File: dv/dpa_host.sv */
// debugger model: makes the link clock and shifts packets on the data pin
// assumes mclk at 8 ns; link period is 20 mclk; data line pulled up when released
`timescale 1ns/10ps
module dpa_host (
    input wire mclk,
    input wire swdio_out,
    input wire swdio_oe,
    output reg swclk,
    output wire swdio_in
);
    reg drv;
    reg drv_en;
    assign swdio_in = swdio_oe ? swdio_out : (drv_en ? drv : 1'b1);
    initial begin
        swclk = 1'b0;
        drv = 1'b0;
        drv_en = 1'b1;
    end
    // one link period: new level at the fall, sample just before the rise
    task cyc(input logic en, input logic b, output logic s);
        begin
            repeat (10) @(posedge mclk);
            #1 swclk = 1'b0;
            drv_en = en;
            drv = b;
            repeat (10) @(posedge mclk);
            #1 s = swdio_in;
            swclk = 1'b1;
        end
    endtask
    task xfer(input logic ap, input logic rd, input logic [1:0] a, input logic bad, input logic [31:0] wd,
              output logic [2:0] ack, output logic [31:0] rdat);
        logic [7:0] h;
        logic s;
        integer i;
        begin
            h = {2'b10, ^{ap, rd, a, bad}, a[1], a[0], rd, ap, 1'b1};
            for (i = 0; i < 8; i++)
                cyc(1'b1, h[i], s);
            for (i = 0; i < 3; i++) begin
                cyc(1'b0, 1'b0, s);
                ack[i] = s;
            end
            rdat = 32'h0;
            if (ack == 3'h1 && rd) begin
                for (i = 0; i < 33; i++) begin
                    cyc(1'b0, 1'b0, s);
                    rdat[i % 32] = (i < 32) ? s : rdat[0];
                    if (i == 32 && s !== ^rdat)
                        rdat = 'x;
                end
            end else if (ack == 3'h1) begin
                cyc(1'b0, 1'b0, s);
                for (i = 0; i < 33; i++)
                    cyc(1'b1, (i < 32) ? wd[i % 32] : ^wd, s);
            end
            cyc(1'b1, 1'b0, s);
        end
    endtask
endmodule

/* File: logic/dpa_consts.vh */
// constants for the debug port front end: request layout, register indices, codes, timing
// assumes inclusion by the front end and its link engine only
`ifndef DPA_CONSTS_VH
`define DPA_CONSTS_VH
// request header bit positions (start, ap/dp, rnw, a2, a3, parity, stop, park)
`define DPA_REQ_START 0
`define DPA_REQ_APNDP 1
`define DPA_REQ_RNW 2
`define DPA_REQ_A2 3
`define DPA_REQ_A3 4
`define DPA_REQ_PAR 5
`define DPA_REQ_STOP 6
`define DPA_REQ_PARK 7
`define DPA_REQ_BITS 8
// acknowledge codes, sent lsb first
`define DPA_ACK_OK 3'h1
`define DPA_ACK_WAIT 3'h2
`define DPA_ACK_FAULT 3'h4
// link-side register index: {bank, a[3:2]}
`define DPA_DP_IDCODE 6'h00
`define DPA_DP_ABORT 6'h00
`define DPA_DP_CTRL 6'h01
`define DPA_DP_ADDRSZ 6'h05
`define DPA_DP_BASE0 6'h09
`define DPA_DP_BASE1 6'h0D
`define DPA_DP_SEL 6'h02
`define DPA_DP_SEL1 6'h15
`define DPA_DP_RDBUFF 6'h03
// sticky flag positions in the control/status word
`define DPA_ST_ORUN 1
`define DPA_ST_WDERR 7
`define DPA_ST_ERR 5
// abort bits
`define DPA_AB_CLR_ERR 2
`define DPA_AB_CLR_WD 3
`define DPA_AB_CLR_ORUN 4
`define DPA_AB_ABORT 0
// reset values and codes; identity and base values are arbitrary neutral values
`define DPA_IDCODE 32'h1000_0001
`define DPA_BASE_LO 32'h0000_0003
`define DPA_BASE_HI 32'h0000_0000
`define DPA_ADDR_BITS 32'h0000_0040
`define DPA_PORT_CLASS 4'h9
// link turnaround in link clock periods; resource-side wait limit in mclk cycles
`define DPA_TURN 1
`define DPA_RES_WAIT_NS 1000
`define DPA_CLK_MHZ 125
`define DPA_RES_WAIT_CYC ((`DPA_RES_WAIT_NS * `DPA_CLK_MHZ) / 1000)
`endif

/* File: logic/dpa_front.v */
// debug port front end: one link-side port, register decode, selection and resource forwarding
// assumes a single resource-side bus on mclk that answers res_done within a bounded time
// How it works
// - one link-side port is the sole external connection to all resource ports
// - two-wire variant shifts packets over clock and data pins
// - request header carries port/resource choice and two address bits
// - acknowledge goes back to host before any data moves
// - data phase only when needed; read outbound, write inbound
// - dual-protocol variant shares pins; debugger picks protocol; here only the two-wire link is built, with no protocol choice
// - selection register, written first, steers resource accesses
// - sticky error flags kept and readable in control/status
// - forwarding of resource accesses needs no extra debugger action
// - transport picks resource from address and moves data both ways
// - identification code and address size are readable
// - base pointer tells debugger where discovery begins
// - abort register cancels a stuck access and clears flags; here only the flags clear, a stuck access ends at the wait limit
// - resource ports report component class nine
// - link-side register chosen by address bits plus bank field
// - two selection fields form a 60-bit bank; address bits pick one of four
// - low two bits of every register address are zero
// - every access moves a full 32-bit word
`timescale 1ns/10ps
`include "dpa_consts.vh"
module dpa_front (
    input wire mclk,
    input wire rst,
    input wire swclk,
    input wire swdio_in,
    output reg swdio_out,
    output reg swdio_oe,
    output reg res_req_r,
    output reg res_wr_r,
    output reg [63:0] res_addr_r,
    output reg [31:0] res_wdata_r,
    input wire [31:0] res_rdata,
    input wire res_done,
    input wire res_err,
    output reg res_abort_r,
    output reg [3:0] port_class_r,
    output reg [31:0] sticky_r,
    output reg link_busy_r
);
    wire l_out;
    wire l_oe;
    wire req_v;
    wire [7:0] req;
    wire wr_v;
    wire [31:0] wdata;
    wire wpar_err;
    wire l_busy;
    reg [2:0] ack_r;
    reg ack_v_r;
    reg [31:0] rdata_r;
    reg [31:0] sel_r;
    reg [31:0] sel1_r;
    reg [31:0] rdbuff_r;
    reg [7:0] cur_r;
    reg pend_r;
    reg [9:0] wait_r;

    // one physical link engine serves every resource port
    dpa_link u_link (
        .mclk(mclk),
        .rst(rst),
        .swclk(swclk),
        .swdio_in(swdio_in),
        .swdio_out_r(l_out),
        .swdio_oe_r(l_oe),
        .req_v_r(req_v),
        .req_r(req),
        .ack(ack_r),
        .ack_v(ack_v_r),
        .rdata(rdata_r),
        .wr_v_r(wr_v),
        .wdata_r(wdata),
        .wpar_err_r(wpar_err),
        .busy_r(l_busy)
    );

    // index of a link-side register from bank field and address bits
    function [5:0] dp_idx;
        input [31:0] sel;
        input [1:0] a;
        begin
            dp_idx = {sel[3:0], a};
        end
    endfunction

    // byte address of a resource register, low bits zero
    function [63:0] ap_addr;
        input [31:0] s1;
        input [31:0] s0;
        input [1:0] a;
        begin
            ap_addr = {s1, s0[31:4], a, 2'b00};
        end
    endfunction

    wire hdr_ok = (req[`DPA_REQ_START] == 1'b1) && (req[`DPA_REQ_STOP] == 1'b0) &&
        (req[`DPA_REQ_PARK] == 1'b1) && ((^req[4:1]) == req[`DPA_REQ_PAR]);
    wire is_ap = req[`DPA_REQ_APNDP];
    wire rnw = req[`DPA_REQ_RNW];
    wire [1:0] a32 = {req[`DPA_REQ_A3], req[`DPA_REQ_A2]};
    wire has_err = sticky_r[`DPA_ST_ERR] | sticky_r[`DPA_ST_WDERR];
    wire [5:0] cidx = dp_idx(sel_r, {cur_r[`DPA_REQ_A3], cur_r[`DPA_REQ_A2]});

    reg [31:0] dp_rd;
    always @* begin
        case (dp_idx(sel_r, a32))
        `DPA_DP_IDCODE: dp_rd = `DPA_IDCODE;
        `DPA_DP_CTRL: dp_rd = sticky_r;
        `DPA_DP_ADDRSZ: dp_rd = `DPA_ADDR_BITS;
        `DPA_DP_BASE0: dp_rd = `DPA_BASE_LO;
        `DPA_DP_BASE1: dp_rd = `DPA_BASE_HI;
        `DPA_DP_RDBUFF: dp_rd = rdbuff_r;
        default: dp_rd = 32'h0000_0000;
        endcase
        if (a32 == 2'b10) begin
            dp_rd = 32'h0000_0000;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            swdio_out <= 1'b0;
            swdio_oe <= 1'b0;
            res_req_r <= 1'b0;
            res_wr_r <= 1'b0;
            res_addr_r <= 64'h0;
            res_wdata_r <= 32'h0000_0000;
            res_abort_r <= 1'b0;
            port_class_r <= 4'h0;
            sticky_r <= 32'h0000_0000;
            link_busy_r <= 1'b0;
            ack_r <= 3'h0;
            ack_v_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            sel_r <= 32'h0000_0000;
            sel1_r <= 32'h0000_0000;
            rdbuff_r <= 32'h0000_0000;
            cur_r <= 8'h00;
            pend_r <= 1'b0;
            wait_r <= 10'h000;
        end else begin
            swdio_out <= l_out;
            swdio_oe <= l_oe;
            link_busy_r <= l_busy | pend_r;
            port_class_r <= `DPA_PORT_CLASS;
            ack_v_r <= 1'b0;
            res_req_r <= 1'b0;
            res_abort_r <= 1'b0;
            if (req_v) begin
                cur_r <= req;
                ack_v_r <= 1'b1;
                // a malformed header is answered with all ones, as an undriven line reads
                if (!hdr_ok) begin
                    ack_r <= 3'h7;
                end else if (pend_r) begin
                    ack_r <= `DPA_ACK_WAIT;
                end else if (is_ap && has_err) begin
                    ack_r <= `DPA_ACK_FAULT;
                end else begin
                    ack_r <= `DPA_ACK_OK;
                    if (!is_ap && rnw) begin
                        rdata_r <= dp_rd;
                    end
                    if (is_ap && rnw) begin
                        // read returns the previous result; the new one is fetched now
                        rdata_r <= rdbuff_r;
                        res_req_r <= 1'b1;
                        res_wr_r <= 1'b0;
                        res_addr_r <= ap_addr(sel1_r, sel_r, a32);
                        pend_r <= 1'b1;
                        wait_r <= 10'h000;
                    end
                end
            end
            if (wr_v && ack_r == `DPA_ACK_OK) begin
                if (wpar_err) begin
                    sticky_r[`DPA_ST_WDERR] <= 1'b1;
                end else if (cur_r[`DPA_REQ_APNDP]) begin
                    res_req_r <= 1'b1;
                    res_wr_r <= 1'b1;
                    res_addr_r <= ap_addr(sel1_r, sel_r, {cur_r[`DPA_REQ_A3], cur_r[`DPA_REQ_A2]});
                    res_wdata_r <= wdata;
                    pend_r <= 1'b1;
                    wait_r <= 10'h000;
                end else if ({cur_r[`DPA_REQ_A3], cur_r[`DPA_REQ_A2]} == 2'b10) begin
                    sel_r <= wdata;
                end else if (cidx == `DPA_DP_SEL1) begin
                    sel1_r <= wdata;
                end else if ({cur_r[`DPA_REQ_A3], cur_r[`DPA_REQ_A2]} == 2'b00) begin
                    // abort clears flags; the cancel never fires, since a request made while pend_r is set gets WAIT
                    if (wdata[`DPA_AB_ABORT] && pend_r) begin
                        res_abort_r <= 1'b1;
                        pend_r <= 1'b0;
                    end
                    if (wdata[`DPA_AB_CLR_ERR]) sticky_r[`DPA_ST_ERR] <= 1'b0;
                    if (wdata[`DPA_AB_CLR_WD]) sticky_r[`DPA_ST_WDERR] <= 1'b0;
                    if (wdata[`DPA_AB_CLR_ORUN]) sticky_r[`DPA_ST_ORUN] <= 1'b0;
                end
            end
            if (pend_r && res_done) begin
                pend_r <= 1'b0;
                if (!res_wr_r) begin
                    rdbuff_r <= res_rdata;
                end
                if (res_err) begin
                    sticky_r[`DPA_ST_ERR] <= 1'b1;
                end
            end else if (pend_r) begin
                wait_r <= wait_r + 10'h001;
                if ({22'h0, wait_r} == `DPA_RES_WAIT_CYC) begin
                    sticky_r[`DPA_ST_ERR] <= 1'b1;
                    res_abort_r <= 1'b1;
                    pend_r <= 1'b0;
                end
            end
            if (req_v && pend_r && hdr_ok) begin
                sticky_r[`DPA_ST_ORUN] <= 1'b1;
            end
        end
    end
endmodule

/* File: logic/dpa_link.v */
// serial two-wire link engine: samples link clock and data, shifts packets in and out
// assumes swclk and swdio_in are asynchronous to mclk; swclk slow against mclk
`timescale 1ns/10ps
`include "dpa_consts.vh"
module dpa_link (
    input wire mclk,
    input wire rst,
    input wire swclk,
    input wire swdio_in,
    output reg swdio_out_r,
    output reg swdio_oe_r,
    output reg req_v_r,
    output reg [7:0] req_r,
    input wire [2:0] ack,
    input wire ack_v,
    input wire [31:0] rdata,
    output reg wr_v_r,
    output reg [31:0] wdata_r,
    output reg wpar_err_r,
    output reg busy_r
);
    localparam S_IDLE = 3'h0;
    localparam S_REQ = 3'h1;
    localparam S_ACKW = 3'h2;
    localparam S_ACK = 3'h3;
    localparam S_RD = 3'h4;
    localparam S_TURN = 3'h5;
    localparam S_WR = 3'h6;
    reg [2:0] ck_s_r;
    reg [1:0] d_s_r;
    reg [2:0] st_r;
    reg [5:0] cnt_r;
    reg [32:0] sh_r;
    reg rnw_r;
    // edges ignored until the synchroniser is filled: no false edge after reset
    reg [1:0] warm_r;
    wire armed = (warm_r == 2'h3);
    wire rise = armed & ck_s_r[1] & ~ck_s_r[2];
    wire fall = armed & ~ck_s_r[1] & ck_s_r[2];
    wire din = d_s_r[1];
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ck_s_r <= 3'h0;
            d_s_r <= 2'h0;
            st_r <= S_IDLE;
            cnt_r <= 6'h00;
            sh_r <= 33'h0;
            rnw_r <= 1'b0;
            warm_r <= 2'h0;
            swdio_out_r <= 1'b0;
            swdio_oe_r <= 1'b0;
            req_v_r <= 1'b0;
            req_r <= 8'h00;
            wr_v_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wpar_err_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            ck_s_r <= {ck_s_r[1:0], swclk};
            d_s_r <= {d_s_r[0], swdio_in};
            if (warm_r != 2'h3) begin
                warm_r <= warm_r + 2'h1;
            end
            req_v_r <= 1'b0;
            wr_v_r <= 1'b0;
            case (st_r)
            S_IDLE: begin
                busy_r <= 1'b0;
                if (rise && din) begin
                    st_r <= S_REQ;
                    cnt_r <= 6'h01;
                    req_r <= 8'h01;
                    busy_r <= 1'b1;
                end
            end
            S_REQ: if (rise) begin
                req_r[cnt_r[2:0]] <= din;
                cnt_r <= cnt_r + 6'h01;
                if (cnt_r == 6'h07) begin
                    req_v_r <= 1'b1;
                    rnw_r <= req_r[`DPA_REQ_RNW];
                    st_r <= S_ACKW;
                end
            end
            S_ACKW: if (ack_v) begin
                sh_r <= {30'h0, ack};
                cnt_r <= 6'h00;
                st_r <= S_ACK;
            end
            S_ACK: if (fall) begin
                swdio_oe_r <= 1'b1;
                swdio_out_r <= sh_r[0];
                sh_r <= {1'b0, sh_r[32:1]};
                cnt_r <= cnt_r + 6'h01;
                if (cnt_r == 6'h03) begin
                    // data phase only for an ok answer, direction from the request
                    if (ack != `DPA_ACK_OK) begin
                        swdio_oe_r <= 1'b0;
                        st_r <= S_IDLE;
                    end else if (rnw_r) begin
                        swdio_out_r <= rdata[0];
                        sh_r <= {1'b0, ^rdata, rdata[31:1]};
                        cnt_r <= 6'h01;
                        st_r <= S_RD;
                    end else begin
                        swdio_oe_r <= 1'b0;
                        cnt_r <= 6'h00;
                        st_r <= S_TURN;
                    end
                end
            end
            S_RD: if (fall) begin
                swdio_out_r <= sh_r[0];
                sh_r <= {1'b0, sh_r[32:1]};
                cnt_r <= cnt_r + 6'h01;
                if (cnt_r == 6'h21) begin
                    swdio_oe_r <= 1'b0;
                    st_r <= S_IDLE;
                end
            end
            S_TURN: if (rise) begin
                cnt_r <= 6'h00;
                st_r <= S_WR;
            end
            S_WR: if (rise) begin
                sh_r <= {din, sh_r[32:1]};
                cnt_r <= cnt_r + 6'h01;
                if (cnt_r == 6'h20) begin
                    wdata_r <= sh_r[32:1];
                    wpar_err_r <= (^sh_r[32:1]) != din;
                    wr_v_r <= 1'b1;
                    st_r <= S_IDLE;
                end
            end
            default: st_r <= S_IDLE;
            endcase
        end
    end
endmodule
